// >>> include/frf_pkg.sv
package frf_pkg;
  // register byte addresses on the AXI4-Lite bus
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_MASK      = 8'h08;
  localparam logic [7:0]  OFS_COUNT     = 8'h0c;
  localparam logic [7:0]  OFS_REC0      = 8'h10;
  localparam logic [7:0]  OFS_REC1      = 8'h14;
  localparam logic [7:0]  OFS_REC2      = 8'h18;
  localparam logic [7:0]  OFS_REC3      = 8'h1c;
  // control bits
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_TLB_BIT    = 1;  // device_tlb_support
  localparam int          CTRL_PASID_BIT  = 2;  // process space id support
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0007;
  localparam logic [31:0] CTRL_WMASK      = 32'h0000_0007;
  // status and mask bits
  localparam int          ST_RECORD_BIT   = 0;  // record produced
  localparam int          ST_DROP_BIT     = 1;  // fault seen while disabled
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] EVENT_WMASK     = 32'h0000_0003;
  // fault kinds
  localparam logic        KIND_XLATE      = 1'b0;
  localparam logic        KIND_INTR       = 1'b1;
  // record field positions
  localparam int          RSV_TOP_BIT     = 127;
  localparam int          ACCESS_BIT      = 126;
  localparam int          ADDR_KIND_LO    = 124;
  localparam int          ADDR_KIND_W     = 2;
  localparam int          SPACE_VAL_LO    = 104;
  localparam int          SPACE_VAL_W     = 20;
  localparam int          CAUSE_LO        = 96;
  localparam int          CAUSE_W         = 8;
  localparam int          SPACE_FLAG_BIT  = 95;
  localparam int          FETCH_BIT       = 94;
  localparam int          SUPER_BIT       = 93;
  localparam int          RSV_MID_LO      = 80;
  localparam int          RSV_MID_W       = 13;
  localparam int          REQ_LO          = 64;
  localparam int          REQ_W           = 16;
  localparam int          DETAIL_LO       = 12;
  localparam int          DETAIL_W        = 52;
  localparam int          INDEX_LO        = 48;
  localparam int          INDEX_W         = 16;
  localparam int          RSV_LOW_W       = 12;
  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : frf_pkg

// >>> src/frf_fault_record_formatter.sv
// Notes on behaviour
// - access bit 126: write 0, read/atomic 1
// - access bit only for translation faults
// - copy address kind into bits 125:124
// - no device tlb support: bits 125:124 zero
// - process space value into bits 123:104
// - no space id support: those fields zero
// - fault cause into bits 103:96
// - bit 95 set when space id present
// - bit 94 fetch asked, needs flag and read
// - bit 93 supervisor asked, needs flag
// - requester ident into bits 79:64
// - translation fault: page address into 63:12
// - interrupt fault: index 63:48, rest cleared
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
module frf_fault_record_formatter (
  input  wire logic          CLK_SYS_IN,
  input  wire logic          RST_N_IN,
  // fault detector side, same clock domain
  input  wire logic          FAULT_VALID_IN,
  input  wire logic          FAULT_KIND_IN,
  input  wire logic          FAULT_WRITE_IN,
  input  wire logic [1:0]    FAULT_ADDR_KIND_IN,
  input  wire logic          FAULT_SPACE_ID_FLAG_IN,
  input  wire logic [19:0]   FAULT_PROCESS_SPACE_VALUE_IN,
  input  wire logic          FAULT_FETCH_PERM_ASKED_IN,
  input  wire logic          FAULT_SUPERVISOR_ASKED_IN,
  input  wire logic [7:0]    FAULT_CAUSE_IN,
  input  wire logic [15:0]   FAULT_REQUESTER_IDENT_IN,
  input  wire logic [51:0]   FAULT_PAGE_ADDR_IN,
  input  wire logic [15:0]   FAULT_INTR_INDEX_IN,
  // record toward the log writer
  output logic      [127:0]  RECORD_OUT,
  output logic               RECORD_VALID_OUT,
  output logic               IRQ_OUT,
  // axi4-lite slave
  input  wire logic [7:0]    S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output logic               S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output logic               S_AXI_WREADY,
  output logic      [1:0]    S_AXI_BRESP,
  output logic               S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  input  wire logic [7:0]    S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output logic               S_AXI_ARREADY,
  output logic      [31:0]   S_AXI_RDATA,
  output logic      [1:0]    S_AXI_RRESP,
  output logic               S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY
);

  logic [127:0] record_reg, record_next;
  logic         rec_valid_reg, rec_valid_next;
  logic [31:0]  ctrl_reg, ctrl_next;
  logic [31:0]  status_reg, status_next;
  logic [31:0]  mask_reg, mask_next;
  logic [31:0]  count_reg, count_next;
  logic [7:0]   awaddr_reg, awaddr_next;
  logic         aw_got_reg, aw_got_next;
  logic [31:0]  wdata_reg, wdata_next;
  logic [3:0]   wstrb_reg, wstrb_next;
  logic         w_got_reg, w_got_next;
  logic         bvalid_reg, bvalid_next;
  logic [1:0]   bresp_reg, bresp_next;
  logic         rvalid_reg, rvalid_next;
  logic [1:0]   rresp_reg, rresp_next;
  logic [31:0]  rdata_reg, rdata_next;
  logic         xl, space_on, tlb_on, flag_ok, take;
  logic [31:0]  ev_set, ev_clr, lane_mask;

  // build the record; fields that only mean something for translation faults are zeroed otherwise
  always_comb begin
    xl       = (FAULT_KIND_IN == frf_pkg::KIND_XLATE);
    space_on = ctrl_reg[frf_pkg::CTRL_PASID_BIT];
    tlb_on   = ctrl_reg[frf_pkg::CTRL_TLB_BIT];
    take     = FAULT_VALID_IN & ctrl_reg[frf_pkg::CTRL_ENABLE_BIT];
    // one gate for every space id field, so support off cannot leak an input value into the log
    flag_ok  = xl & space_on & FAULT_SPACE_ID_FLAG_IN;
    record_next = record_reg;
    rec_valid_next = take;
    if (take) begin
      record_next = '0;
      record_next[frf_pkg::ACCESS_BIT] = xl & ~FAULT_WRITE_IN;
      if (xl && tlb_on) begin
        record_next[frf_pkg::ADDR_KIND_LO +: frf_pkg::ADDR_KIND_W] = FAULT_ADDR_KIND_IN;
      end
      if (flag_ok) begin
        record_next[frf_pkg::SPACE_VAL_LO +: frf_pkg::SPACE_VAL_W] = FAULT_PROCESS_SPACE_VALUE_IN;
      end
      record_next[frf_pkg::CAUSE_LO +: frf_pkg::CAUSE_W] = FAULT_CAUSE_IN;
      record_next[frf_pkg::SPACE_FLAG_BIT] = flag_ok;
      record_next[frf_pkg::FETCH_BIT] = flag_ok & ~FAULT_WRITE_IN & FAULT_FETCH_PERM_ASKED_IN;
      record_next[frf_pkg::SUPER_BIT] = flag_ok & FAULT_SUPERVISOR_ASKED_IN;
      record_next[frf_pkg::REQ_LO +: frf_pkg::REQ_W] = FAULT_REQUESTER_IDENT_IN;
      if (xl) begin
        record_next[frf_pkg::DETAIL_LO +: frf_pkg::DETAIL_W] = FAULT_PAGE_ADDR_IN;
      end else begin
        record_next[frf_pkg::INDEX_LO +: frf_pkg::INDEX_W] = FAULT_INTR_INDEX_IN;
      end
    end
  end

  // record path registers; the record holds until the next fault taken with enable on, so software can read it back
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      record_reg    <= '0;
      rec_valid_reg <= 1'b0;
    end else begin
      record_reg    <= record_next;
      rec_valid_reg <= rec_valid_next;
    end
  end

  // bus slave and register file; one write and one read in flight, address and data in any order
  always_comb begin
    awaddr_next = awaddr_reg;
    aw_got_next = aw_got_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    w_got_next  = w_got_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    ctrl_next   = ctrl_reg;
    mask_next   = mask_reg;
    ev_clr      = '0;
    lane_mask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    // address and data are latched apart, so the master may offer either one first
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      awaddr_next = S_AXI_AWADDR;
      aw_got_next = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      wdata_next = S_AXI_WDATA;
      wstrb_next = S_AXI_WSTRB;
      w_got_next = 1'b1;
    end
    if (aw_got_reg && w_got_reg && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = frf_pkg::RESP_OKAY;
      case (awaddr_reg)
        frf_pkg::OFS_CTRL: begin
          ctrl_next = (ctrl_reg & ~(lane_mask & frf_pkg::CTRL_WMASK)) | (wdata_reg & lane_mask & frf_pkg::CTRL_WMASK);
        end
        frf_pkg::OFS_STATUS: begin
          ev_clr = wdata_reg & lane_mask & frf_pkg::EVENT_WMASK; // write one to clear
        end
        frf_pkg::OFS_MASK: begin
          mask_next = (mask_reg & ~(lane_mask & frf_pkg::EVENT_WMASK)) |
                      (wdata_reg & lane_mask & frf_pkg::EVENT_WMASK);
        end
        frf_pkg::OFS_COUNT, frf_pkg::OFS_REC0, frf_pkg::OFS_REC1, frf_pkg::OFS_REC2, frf_pkg::OFS_REC3: begin
          bresp_next = frf_pkg::RESP_OKAY; // read-only, write ignored
        end
        default: begin
          bresp_next = frf_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    // read data is registered so it stands unchanged while rvalid waits for rready
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next  = frf_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        frf_pkg::OFS_CTRL:   rdata_next = ctrl_reg;
        frf_pkg::OFS_STATUS: rdata_next = status_reg;
        frf_pkg::OFS_MASK:   rdata_next = mask_reg;
        frf_pkg::OFS_COUNT:  rdata_next = count_reg;
        frf_pkg::OFS_REC0:   rdata_next = record_reg[31:0];
        frf_pkg::OFS_REC1:   rdata_next = record_reg[63:32];
        frf_pkg::OFS_REC2:   rdata_next = record_reg[95:64];
        frf_pkg::OFS_REC3:   rdata_next = record_reg[127:96];
        default: begin
          rdata_next = '0;
          rresp_next = frf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    // sticky events: a set in the same cycle as its clear wins, so no event is lost
    ev_set = '0;
    ev_set[frf_pkg::ST_RECORD_BIT] = take;
    ev_set[frf_pkg::ST_DROP_BIT]   = FAULT_VALID_IN & ~ctrl_reg[frf_pkg::CTRL_ENABLE_BIT];
    status_next = (status_reg & ~ev_clr) | ev_set;
    count_next  = take ? count_reg + 32'h0000_0001 : count_reg;
  end

  // bus and register file flops
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      awaddr_reg <= '0;
      aw_got_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
      w_got_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= frf_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= frf_pkg::RESP_OKAY;
      rdata_reg  <= '0;
      ctrl_reg   <= frf_pkg::CTRL_RESET;
      status_reg <= frf_pkg::STATUS_RESET;
      mask_reg   <= frf_pkg::MASK_RESET;
      count_reg  <= '0;
    end else begin
      awaddr_reg <= awaddr_next;
      aw_got_reg <= aw_got_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      w_got_reg  <= w_got_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      ctrl_reg   <= ctrl_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      count_reg  <= count_next;
    end
  end

  // outputs; readies stay low while a response waits so nothing new is taken
  assign RECORD_OUT       = record_reg;
  assign RECORD_VALID_OUT = rec_valid_reg;
  assign IRQ_OUT          = |(status_reg & mask_reg);
  assign S_AXI_AWREADY    = ~aw_got_reg & ~bvalid_reg;
  assign S_AXI_WREADY     = ~w_got_reg & ~bvalid_reg;
  assign S_AXI_BVALID     = bvalid_reg;
  assign S_AXI_BRESP      = bresp_reg;
  assign S_AXI_ARREADY    = ~rvalid_reg;
  assign S_AXI_RVALID     = rvalid_reg;
  assign S_AXI_RDATA      = rdata_reg;
  assign S_AXI_RRESP      = rresp_reg;

  // checks on the produced record
  default clocking frf_cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);

  AST_ACCESS_KIND: assert property (take && xl |=> RECORD_VALID_OUT &&
      RECORD_OUT[126] == !$past(FAULT_WRITE_IN))
    else $error("access kind bit wrong for translation fault");
  AST_ACCESS_ONLY_XLATE: assert property (take && !xl |=> RECORD_OUT[126] == 1'b0)
    else $error("access kind bit set on interrupt fault");
  AST_ADDR_KIND: assert property (take && xl && tlb_on |=> RECORD_OUT[125:124] == $past(FAULT_ADDR_KIND_IN))
    else $error("address kind not copied");
  AST_NO_TLB: assert property (take && !tlb_on |=> RECORD_OUT[125:124] == 2'h0)
    else $error("address kind not zero without tlb support");
  AST_SPACE_VALUE: assert property (take && flag_ok |=>
      RECORD_OUT[123:104] == $past(FAULT_PROCESS_SPACE_VALUE_IN))
    else $error("process space value not copied");
  AST_NO_SPACE: assert property (take && !space_on |=> RECORD_OUT[123:104] == 20'h0 && RECORD_OUT[95:93] == 3'h0)
    else $error("space id fields not zero without support");
  AST_CAUSE: assert property (take |=> RECORD_OUT[103:96] == $past(FAULT_CAUSE_IN))
    else $error("fault cause not copied");
  AST_FLAG: assert property (take |=> RECORD_OUT[95] == $past(flag_ok))
    else $error("space id flag wrong");
  AST_FETCH: assert property (RECORD_VALID_OUT && RECORD_OUT[94] |-> RECORD_OUT[95] && RECORD_OUT[126])
    else $error("fetch bit without flag and read");
  AST_SUPER: assert property (RECORD_VALID_OUT && RECORD_OUT[93] |-> RECORD_OUT[95])
    else $error("supervisor bit without flag");
  AST_REQUESTER: assert property (take |=> RECORD_OUT[79:64] == $past(FAULT_REQUESTER_IDENT_IN))
    else $error("requester ident not copied");
  AST_PAGE: assert property (take && xl |=> RECORD_OUT[63:12] == $past(FAULT_PAGE_ADDR_IN))
    else $error("page address not copied");
  AST_INDEX: assert property (take && !xl |=> RECORD_OUT[63:48] == $past(FAULT_INTR_INDEX_IN) &&
      RECORD_OUT[47:12] == 36'h0)
    else $error("interrupt index or cleared bits wrong");
  AST_RESERVED: assert property (RECORD_VALID_OUT |-> RECORD_OUT[127] == 1'b0 &&
      RECORD_OUT[92:80] == 13'h0 && RECORD_OUT[11:0] == 12'h0)
    else $error("reserved record bits not zero");

  // the one-way checks above would still hold with the bits stuck at zero, so check the copies too
  AST_FETCH_SET: assert property (take && flag_ok && !FAULT_WRITE_IN |=>
      RECORD_OUT[94] == $past(FAULT_FETCH_PERM_ASKED_IN))
    else $error("fetch bit not copied for space id read");
  AST_SUPER_SET: assert property (take && flag_ok |=> RECORD_OUT[93] == $past(FAULT_SUPERVISOR_ASKED_IN))
    else $error("supervisor bit not copied");
  AST_INTR_ZERO: assert property (take && !xl |=> RECORD_OUT[125:104] == 22'h0 && RECORD_OUT[95:93] == 3'h0)
    else $error("translation-only fields set on interrupt fault");

  COV_XLATE_READ: cover property (take && xl && !FAULT_WRITE_IN ##1 RECORD_VALID_OUT);
  COV_INTR: cover property (take && !xl ##1 RECORD_VALID_OUT);
  COV_SPACE_FETCH: cover property (take && flag_ok && FAULT_FETCH_PERM_ASKED_IN && !FAULT_WRITE_IN);
  COV_IRQ: cover property (!IRQ_OUT ##1 IRQ_OUT);
  // support off while the request still carries an id: the forced-zero path
  COV_NO_SPACE: cover property (take && xl && !space_on && FAULT_SPACE_ID_FLAG_IN);

endmodule // frf_fault_record_formatter

// >>> bench/frf_log_model.sv
module frf_log_model (
  input  wire logic         clk_in,
  input  wire logic         rec_valid_in,
  input  wire logic [127:0] rec_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // fault log in memory: each handed-over record takes the next slot, never overwritten
  logic [127:0] log_q[$];
  always @(posedge clk_in) begin
    if (rec_valid_in) begin
      log_q.push_back(rec_in);
    end
  end
endmodule // frf_log_model

// >>> bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk, rst_n, fv, fk, fw, fsf, ffe, fsa, rec_v, irq;
  logic [1:0]   fak, bresp, rresp;
  logic [19:0]  fpv;
  logic [7:0]   fc, awaddr, araddr;
  logic [15:0]  fri, fii;
  logic [51:0]  fpa;
  logic [127:0] rec, exp_rec;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [2:0]   ctrl;
  logic [2:0]   cfg [4] = '{3'h7, 3'h5, 3'h3, 3'h1};
  integer       seed = 83788;
  int           error_cnt = 0;
  int           checks = 0;
  int           n_rec = 0;

  frf_fault_record_formatter u_dut (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .FAULT_VALID_IN(fv), .FAULT_KIND_IN(fk), .FAULT_WRITE_IN(fw),
    .FAULT_ADDR_KIND_IN(fak), .FAULT_SPACE_ID_FLAG_IN(fsf), .FAULT_PROCESS_SPACE_VALUE_IN(fpv),
    .FAULT_FETCH_PERM_ASKED_IN(ffe), .FAULT_SUPERVISOR_ASKED_IN(fsa), .FAULT_CAUSE_IN(fc),
    .FAULT_REQUESTER_IDENT_IN(fri), .FAULT_PAGE_ADDR_IN(fpa), .FAULT_INTR_INDEX_IN(fii),
    .RECORD_OUT(rec), .RECORD_VALID_OUT(rec_v), .IRQ_OUT(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready)
  );
  frf_log_model u_log (.clk_in(clk), .rec_valid_in(rec_v), .rec_in(rec));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] expv);
    checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // expected record from the fields being taken at this edge and the support bits in ctrl
  function automatic logic [127:0] calc();
    logic [127:0] r = '0;
    r[103:96] = fc;
    r[79:64] = fri;
    if (fk == frf_pkg::KIND_XLATE) begin
      r[126] = ~fw;
      if (ctrl[frf_pkg::CTRL_TLB_BIT]) r[125:124] = fak;
      if (ctrl[frf_pkg::CTRL_PASID_BIT] && fsf) begin
        r[123:104] = fpv;
        r[95] = 1'b1;
        r[94] = ffe & ~fw;
        r[93] = fsa;
      end
      r[63:12] = fpa;
    end else begin
      r[63:48] = fii;
    end
    return r;
  endfunction

  // bus tasks hold each valid until its own ready is seen at an edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] s = 4'hf);
    logic ad = 1'b0;
    logic wd = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awready) ad = 1'b1;
      if (wready) wd = 1'b1;
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    do @(posedge clk); while (!bvalid);
    check("bresp", 128'(bresp), 128'(er));
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    check("rdata", 128'(rdata), 128'(ed));
    check("rresp", 128'(rresp), 128'(er));
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // random faults, back to back most cycles; the record is checked one edge after it is taken
  task automatic run(input int n);
    logic [63:0] a, b;
    logic        took = 1'b0;
    // one extra edge after the last strobe so its record is compared inside the run
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge clk);
      check("record_valid", 128'(rec_v), 128'(took));
      check("record", rec, exp_rec);
      took = fv & ctrl[frf_pkg::CTRL_ENABLE_BIT];
      if (took) exp_rec = calc();
      if (took) n_rec++;
      a = (i == 0) ? '1 : {$random(seed), $random(seed)};
      b = (i == 0) ? '1 : {$random(seed), $random(seed)};
      fk  <= a[0];
      fw  <= a[1];
      fsf <= a[2];
      ffe <= a[3];
      fsa <= a[4];
      fak <= a[6:5];
      fc  <= a[15:8];
      fri <= a[31:16];
      fpv <= a[51:32];
      fii <= a[63:48];
      fpa <= b[51:0];
      fv <= (i < n) ? (a[7] | a[53]) : 1'b0;
    end
  endtask

  initial begin
    rst_n   = 1'b0;
    fv      = 1'b0;
    fk      = 1'b0;
    fw      = 1'b0;
    fsf     = 1'b0;
    ffe     = 1'b0;
    fsa     = 1'b0;
    fak     = '0;
    fpv     = '0;
    fc      = '0;
    fri     = '0;
    fii     = '0;
    fpa     = '0;
    awaddr  = '0;
    awvalid = 1'b0;
    wdata   = '0;
    wstrb   = '0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = '0;
    arvalid = 1'b0;
    rready  = 1'b0;
    exp_rec = '0;
    ctrl = 3'h7;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(frf_pkg::OFS_CTRL, frf_pkg::CTRL_RESET, frf_pkg::RESP_OKAY);
    axi_rd(8'h40, 32'h0, frf_pkg::RESP_SLVERR);
    axi_wr(8'h40, 32'hffff_ffff, frf_pkg::RESP_SLVERR);
    // a write whose strobe leaves out the only byte lane in use must not touch control
    axi_wr(frf_pkg::OFS_CTRL, 32'h0, frf_pkg::RESP_OKAY, 4'he);
    axi_rd(frf_pkg::OFS_CTRL, frf_pkg::CTRL_RESET, frf_pkg::RESP_OKAY);
    $display("test reset_and_map done");
    // sweep every combination of the two support bits with enable on
    foreach (cfg[k]) begin
      ctrl = cfg[k];
      axi_wr(frf_pkg::OFS_CTRL, {29'h0, ctrl}, frf_pkg::RESP_OKAY);
      run(30);
    end
    // let the log model take the last record before its size is read
    @(posedge clk);
    check("log_size", 128'(u_log.log_q.size()), 128'(n_rec));
    check("log_last", u_log.log_q[$], exp_rec);
    for (int w = 0; w < 4; w++) axi_rd(frf_pkg::OFS_REC0 + 8'(4 * w), exp_rec[32 * w +: 32], frf_pkg::RESP_OKAY);
    axi_wr(frf_pkg::OFS_COUNT, 32'h0, frf_pkg::RESP_OKAY);
    axi_rd(frf_pkg::OFS_COUNT, 32'(n_rec), frf_pkg::RESP_OKAY);
    $display("test records done");
    // interrupt: unmask, clear by writing one, then the dropped-fault event while disabled
    axi_wr(frf_pkg::OFS_MASK, 32'h1, frf_pkg::RESP_OKAY);
    check("irq_set", 128'(irq), 128'(1'b1));
    axi_wr(frf_pkg::OFS_STATUS, 32'h1, frf_pkg::RESP_OKAY);
    check("irq_clr", 128'(irq), 128'(1'b0));
    ctrl = 3'h6;
    axi_wr(frf_pkg::OFS_CTRL, 32'h6, frf_pkg::RESP_OKAY);
    run(10);
    axi_rd(frf_pkg::OFS_STATUS, 32'h2, frf_pkg::RESP_OKAY);
    axi_wr(frf_pkg::OFS_MASK, 32'h3, frf_pkg::RESP_OKAY);
    axi_rd(frf_pkg::OFS_MASK, 32'h3, frf_pkg::RESP_OKAY);
    check("irq_drop", 128'(irq), 128'(1'b1));
    axi_wr(frf_pkg::OFS_STATUS, 32'h2, frf_pkg::RESP_OKAY);
    check("irq_drop_clr", 128'(irq), 128'(1'b0));
    $display("test interrupt done");
    conclude();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end
endmodule // tb_top
